// [design/sync_serial_ctrl_status.sv]
// Purpose: Control, status, FIFO counts and bit rate of a synchronous serial port
// Assumes: FIFO storage and shift registers sit outside and report their events
// Notes: Registers on a plain strobe port, read data one cycle after the strobe
`timescale 1ns/1ps
`include "sync_serial_defines.svh"
module sync_serial_ctrl_status
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input sync_serial_pkg::reg_req_s reg_req,
   output logic [15:0] reg_rdata,
   output logic tx_fifo_wr,
   output logic [7:0] tx_fifo_wdata,
   input wire logic tx_load,
   input wire logic tx_char_done,
   output logic tx_data_ready,
   input wire logic rx_byte_valid,
   output logic rx_accept,
   output logic rx_fifo_rd,
   input wire logic [7:0] rx_fifo_rdata,
   output logic tx_fifo_clear,
   output logic rx_fifo_clear,
   output logic tx_active,
   output logic rx_active,
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe,
   output sync_serial_pkg::sclk_s serial_clk,
   output logic tx_irq,
   output logic rx_irq
);
   import sync_serial_pkg::*;

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // ****************************************
   // Declarations
   // ****************************************
   ctrl_s ctrl_q;
   logic [1:0] cks_q;
   logic [7:0] brr_q;
   logic [6:0] fst_q;
   logic stop_count_enable_q;
   logic tfrst_q;
   logic rfrst_q;
   logic tx_done_flag_q;
   logic tx_done_flag_d;
   logic tstop_q;
   logic tstop_d;
   logic rstop_q;
   logic rstop_d;
   logic tarm_q;
   logic tarm_d;
   logic rarm_q;
   logic rarm_d;
   logic [8:0] tx_cnt_q;
   logic [8:0] tx_cnt_d;
   logic [8:0] rx_cnt_q;
   logic [8:0] rx_cnt_d;
   logic [7:0] sent_q;
   logic [7:0] sent_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic sclk_pin_q;

   // ****************************************
   // Address decode
   // ****************************************
   logic wr_cks;
   logic wr_brr;
   logic wr_ctrl;
   logic wr_line;
   logic wr_status;
   logic wr_fcr;
   logic wr_txp;
   logic rd_status;
   logic rd_rxp;

   assign wr_cks = reg_req.wr && (reg_req.addr == `OFS_CLK_SEL);
   assign wr_brr = reg_req.wr && (reg_req.addr == `OFS_BIT_RATE);
   assign wr_ctrl = reg_req.wr && (reg_req.addr == `OFS_CTRL);
   assign wr_line = reg_req.wr && (reg_req.addr == `OFS_LINE);
   assign wr_status = reg_req.wr && (reg_req.addr == `OFS_STATUS);
   assign wr_fcr = reg_req.wr && (reg_req.addr == `OFS_FIFO_CTL);
   assign wr_txp = reg_req.wr && (reg_req.addr == `OFS_TX_PORT);
   assign rd_status = reg_req.rd && (reg_req.addr == `OFS_STATUS);
   assign rd_rxp = reg_req.rd && (reg_req.addr == `OFS_RX_PORT);

   // ****************************************
   // FIFO occupancy
   // ****************************************
   logic tx_full;
   logic tx_empty;
   logic rx_full;
   logic rx_empty;
   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;

   assign tx_full = (tx_cnt_q == `TX_DEPTH);
   assign rx_full = (rx_cnt_q == `RX_DEPTH);
   assign tx_empty = (tx_cnt_q == 9'h000);
   assign rx_empty = (rx_cnt_q == 9'h000);
   // A write to a full transmit FIFO is dropped
   assign tx_push = wr_txp && !tx_full && !tfrst_q;
   assign tx_pop = tx_load && !tx_empty && !tfrst_q;
   assign rx_push = rx_byte_valid && rx_accept;
   // Empty read leaves the count alone and fetches nothing
   assign rx_pop = rd_rxp && !rx_empty && !rfrst_q;

   assign tx_cnt_d = tfrst_q ? 9'h000 : tx_cnt_q + {8'h00, tx_push} - {8'h00, tx_pop};
   assign rx_cnt_d = rfrst_q ? 9'h000 : rx_cnt_q + {8'h00, rx_push} - {8'h00, rx_pop};

   // ****************************************
   // Flag events
   // ****************************************
   logic tstop_set;
   logic rstop_set;
   logic tx_done_flag_set;
   logic tstop_clr;
   logic rstop_clr;
   logic [8:0] stop_bytes;

   assign stop_bytes = {2'h0, fst_q};
   // Field holds bytes minus one, so compare the count before this byte
   assign tstop_set = stop_count_enable_q && tx_pop && (sent_q == {1'b0, fst_q});
   assign rstop_set = rx_push && (stop_count_enable_q ? (rx_cnt_q == stop_bytes)
                                         : (rx_cnt_q == `RX_DEPTH - 9'h001));
   assign tx_done_flag_set = tx_char_done && tx_empty;
   // Clear only by a zero after a read that saw the flag high
   assign tstop_clr = wr_status && !reg_req.wdata[`ST_TSTOP] && tarm_q;
   assign rstop_clr = wr_status && !reg_req.wdata[`ST_RSTOP] && rarm_q;

   // Set wins over a clear in the same cycle
   assign tstop_d = tstop_set ? 1'b1 : tstop_clr ? 1'b0 : tstop_q;
   // Clearing the receive enable does not touch this flag
   assign rstop_d = rstop_set ? 1'b1 : rstop_clr ? 1'b0 : rstop_q;
   assign tx_done_flag_d = tx_done_flag_set ? 1'b1 : tx_push ? 1'b0 : tx_done_flag_q;

   assign tarm_d = rd_status ? tstop_q : wr_status ? 1'b0 : tarm_q;
   assign rarm_d = rd_status ? rstop_q : wr_status ? 1'b0 : rarm_q;

   // Moved-byte counter restarts once the stop is acknowledged
   assign sent_d = (!stop_count_enable_q || tfrst_q || tstop_clr) ? 8'h00 :
                   tx_pop ? sent_q + 8'h01 : sent_q;

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge sys_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         ctrl_q <= ctrl_s'(6'(`CTRL_RST));
         cks_q <= `CKS_RST;
         brr_q <= `BRR_RST;
         fst_q <= `FST_RST;
         stop_count_enable_q <= 1'b0;
         tfrst_q <= 1'b0;
         rfrst_q <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_q <= {reg_req.wdata[`CTRL_TIE:`CTRL_RE],
                       reg_req.wdata[`CTRL_CKE_HI:`CTRL_CKE_LO]};
         end
         if (wr_cks)
         begin
            cks_q <= reg_req.wdata[1:0];
         end
         if (wr_brr)
         begin
            brr_q <= reg_req.wdata[7:0];
         end
         if (wr_line)
         begin
            fst_q <= reg_req.wdata[`LINE_FST_HI:`LINE_FST_LO];
            stop_count_enable_q <= reg_req.wdata[`LINE_STOP_COUNT_ENABLE];
         end
         if (wr_fcr)
         begin
            tfrst_q <= reg_req.wdata[`FCR_TFRST];
            rfrst_q <= reg_req.wdata[`FCR_RFRST];
         end
      end
   end

   // ****************************************
   // Status flags and counts
   // ****************************************
   always_ff @(posedge sys_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         tx_done_flag_q <= 1'(`STATUS_RST >> `ST_TX_DONE_FLAG);
         tstop_q <= 1'b0;
         rstop_q <= 1'b0;
         tarm_q <= 1'b0;
         rarm_q <= 1'b0;
         tx_cnt_q <= 9'h000;
         rx_cnt_q <= 9'h000;
         sent_q <= 8'h00;
      end
      else
      begin
         tx_done_flag_q <= tx_done_flag_d;
         tstop_q <= tstop_d;
         rstop_q <= rstop_d;
         tarm_q <= tarm_d;
         rarm_q <= rarm_d;
         tx_cnt_q <= tx_cnt_d;
         rx_cnt_q <= rx_cnt_d;
         sent_q <= sent_d;
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   logic [15:0] ctrl_rd;
   logic [15:0] status_rd;
   logic [15:0] line_rd;
   logic [15:0] fcr_rd;

   // Reserved bits are held at zero in the read words, except bit 2 of the line word, which reads one
   assign ctrl_rd = {8'h00, ctrl_q[5:2], 2'h0, ctrl_q[1:0]};
   assign status_rd = {9'h000, tx_done_flag_q, tstop_q, 3'h0, rstop_q, 1'b0};
   assign line_rd = {1'b0, fst_q, 3'h0, stop_count_enable_q, 1'b0, 1'b1, 2'h0};
   assign fcr_rd = {13'h0000, tfrst_q, rfrst_q, 1'b0};

   always_comb
   begin
      rdata_d = 16'h0000;
      if (reg_req.rd)
      begin
         unique case (reg_req.addr)
            `OFS_CLK_SEL: rdata_d = {14'h0000, cks_q};
            `OFS_BIT_RATE: rdata_d = {8'h00, brr_q};
            `OFS_CTRL: rdata_d = ctrl_rd;
            `OFS_LINE: rdata_d = line_rd;
            `OFS_STATUS: rdata_d = status_rd;
            `OFS_RX_CNT: rdata_d = {7'h00, rx_cnt_q};
            `OFS_FIFO_CTL: rdata_d = fcr_rd;
            `OFS_TX_CNT: rdata_d = {7'h00, tx_cnt_q};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   // Receive port data come a cycle later from the outside storage
   logic rxp_q;

   always_ff @(posedge sys_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         rdata_q <= 16'h0000;
         rxp_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         rxp_q <= rd_rxp;
      end
   end

   // On an empty read the storage output is passed through unchecked
   assign reg_rdata = rxp_q ? {8'h00, rx_fifo_rdata} : rdata_q;

   // ****************************************
   // Transmit write data
   // ****************************************
   logic [7:0] txw_data_q;
   logic txw_q;

   always_ff @(posedge sys_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         txw_q <= 1'b0;
         txw_data_q <= 8'h00;
      end
      else
      begin
         txw_q <= tx_push;
         txw_data_q <= tx_push ? reg_req.wdata[7:0] : txw_data_q;
      end
   end

   assign tx_fifo_wr = txw_q;
   assign tx_fifo_wdata = txw_data_q;
   assign rx_fifo_rd = rx_pop;
   assign tx_fifo_clear = tfrst_q;
   assign rx_fifo_clear = rfrst_q;

   // ****************************************
   // Enables
   // ****************************************
   // A pending stop halts further moves until software acknowledges it
   assign tx_data_ready = ctrl_q.tx_enable && !tx_empty && !tfrst_q && !tstop_q;
   assign tx_active = ctrl_q.tx_enable;
   assign rx_active = ctrl_q.rx_enable;
   assign rx_accept = ctrl_q.rx_enable && !rx_full && !rfrst_q && !rstop_q;

   // ****************************************
   // Serial clock source
   // ****************************************
   logic internal_clk;
   logic gen_run;
   sclk_s gen_clk;
   sclk_s ext_clk;

   assign internal_clk = !ctrl_q.clk_source[1];
   assign gen_run = internal_clk && (ctrl_q.tx_enable || ctrl_q.rx_enable);

   baud_gen u_baud
   (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_q),
      .run(gen_run),
      .prescale_sel(cks_q),
      .divisor(brr_q),
      .sclk(gen_clk)
   );

   // Pin is already synchronous, one stage only for edge detection
   always_ff @(posedge sys_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         sclk_pin_q <= 1'b1;
      end
      else
      begin
         sclk_pin_q <= serial_clock_pin_i;
      end
   end

   assign ext_clk.level = serial_clock_pin_i;
   assign ext_clk.rise = serial_clock_pin_i && !sclk_pin_q;
   assign ext_clk.fall = !serial_clock_pin_i && sclk_pin_q;

   // In mode 00 the pin level is never looked at
   assign serial_clk = internal_clk ? gen_clk : ext_clk;
   assign serial_clock_pin_oe = (ctrl_q.clk_source == `CKE_INT_OUT);
   assign serial_clock_pin_o = gen_clk.level;

   // ****************************************
   // Interrupt requests
   // ****************************************
   assign tx_irq = ctrl_q.tx_irq_enable && tstop_q;
   assign rx_irq = ctrl_q.rx_irq_enable && rstop_q;

endmodule : sync_serial_ctrl_status

// [inc/sync_serial_defines.svh]
// Purpose: Named offsets, field positions, reset values and counts of the serial port
// Assumes: Byte offsets on a 5-bit register address
// Notes: Definitions only
`ifndef SYNC_SERIAL_DEFINES_SVH
`define SYNC_SERIAL_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_CLK_SEL 5'h00
`define OFS_BIT_RATE 5'h02
`define OFS_CTRL 5'h04
`define OFS_LINE 5'h06
`define OFS_STATUS 5'h08
`define OFS_RX_CNT 5'h0a
`define OFS_FIFO_CTL 5'h0c
`define OFS_TX_PORT 5'h10
`define OFS_RX_PORT 5'h14
`define OFS_TX_CNT 5'h18

// ****************************************
// Field positions
// ****************************************
`define CTRL_TIE 7
`define CTRL_RIE 6
`define CTRL_TE 5
`define CTRL_RE 4
`define CTRL_CKE_HI 1
`define CTRL_CKE_LO 0
`define ST_TX_DONE_FLAG 6
`define ST_TSTOP 5
`define ST_RSTOP 1
`define LINE_FST_HI 14
`define LINE_FST_LO 8
`define LINE_STOP_COUNT_ENABLE 4
`define LINE_ONE 2
`define FCR_TFRST 2
`define FCR_RFRST 1

// ****************************************
// Reset values and codes
// ****************************************
`define CTRL_RST 8'h00
`define STATUS_RST 16'h0040
`define BRR_RST 8'hff
`define CKS_RST 2'h0
`define FST_RST 7'h00
`define CKE_INT_IN 2'h0
`define CKE_INT_OUT 2'h1
`define TX_DEPTH 9'h080
`define RX_DEPTH 9'h180
`define PRE_MASK0 6'h00
`define PRE_MASK1 6'h03
`define PRE_MASK2 6'h0f
`define PRE_MASK3 6'h3f

`endif

// [inc/sync_serial_pkg.sv]
// Purpose: Types shared by the serial port control files
// Assumes: Nothing beyond the defines header
// Notes: Control word matches the control register bit order
package sync_serial_pkg;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic tx_irq_enable;
      logic rx_irq_enable;
      logic tx_enable;
      logic rx_enable;
      logic [1:0] clk_source;
   } ctrl_s;

   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic level;
      logic rise;
      logic fall;
   } sclk_s;

endpackage : sync_serial_pkg

// [design/baud_gen.sv]
// Purpose: Bit rate generator, prescaler then divider, toggling a serial clock
// Assumes: Synchronous reset copy from the top
// Notes: Clock period is 4 x 4^n x (N+1) input cycles
`timescale 1ns/1ps
`include "sync_serial_defines.svh"
module baud_gen
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [1:0] prescale_sel,
   input wire logic [7:0] divisor,
   output sync_serial_pkg::sclk_s sclk
);
   import sync_serial_pkg::*;

   logic [5:0] pre_q;
   logic [5:0] pre_d;
   logic [8:0] div_q;
   logic [8:0] div_d;
   logic lvl_q;
   logic lvl_d;
   logic [5:0] mask;
   logic pre_tick;
   logic [8:0] half_cnt;
   logic half_end;

   // ****************************************
   // Prescaler and divider
   // ****************************************
   assign mask = (prescale_sel == 2'h0) ? `PRE_MASK0 :
                 (prescale_sel == 2'h1) ? `PRE_MASK1 :
                 (prescale_sel == 2'h2) ? `PRE_MASK2 : `PRE_MASK3;
   assign pre_tick = run && ((pre_q & mask) == mask);
   // Half period is 2(N+1) prescaled ticks, so a full bit is 4(N+1)
   assign half_cnt = {divisor, 1'b1};
   assign half_end = pre_tick && (div_q >= half_cnt);
   assign pre_d = run ? pre_q + 6'h01 : 6'h00;
   assign div_d = !run ? 9'h000 : half_end ? 9'h000 : pre_tick ? div_q + 9'h001 : div_q;
   assign lvl_d = !run ? 1'b1 : half_end ? !lvl_q : lvl_q;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_q <= 6'h00;
         div_q <= 9'h000;
         lvl_q <= 1'b1;
      end
      else
      begin
         pre_q <= pre_d;
         div_q <= div_d;
         lvl_q <= lvl_d;
      end
   end

   assign sclk.level = lvl_q;
   assign sclk.rise = half_end && !lvl_q;
   assign sclk.fall = half_end && lvl_q;

endmodule : baud_gen

// [tb/sync_serial_chk.sv]
// Purpose: Port checks of the serial control block
// Assumes: Strobe register port, read data one cycle after the strobe
// Notes: Bound to the design top
`timescale 1ns/1ps
`include "sync_serial_defines.svh"
module sync_serial_chk
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input sync_serial_pkg::reg_req_s reg_req,
   input wire logic [15:0] reg_rdata,
   input wire logic tx_load,
   input wire logic tx_data_ready,
   input wire logic rx_accept,
   input wire logic rx_fifo_rd,
   input wire logic tx_active,
   input wire logic rx_active,
   input wire logic serial_clock_pin_oe,
   input wire logic tx_irq,
   input wire logic rx_irq
);
   import sync_serial_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire ctrl_wr = reg_req.wr && reg_req.addr == `OFS_CTRL;
   wire wr_st = reg_req.wr && reg_req.addr == `OFS_STATUS;
   wire rd_st = reg_req.rd && reg_req.addr == `OFS_STATUS;
   wire rd_ctrl = reg_req.rd && reg_req.addr == `OFS_CTRL;
   // ****************************************
   // Assertions
   // ****************************************
   sequence tx_flag_seen;
      rd_st ##1 reg_rdata[`ST_TSTOP];
   endsequence
   sequence tx_flag_zeroed;
      wr_st && !reg_req.wdata[`ST_TSTOP] && !tx_load;
   endsequence
   ctrl_rsvd_zero_a: assert property (rd_ctrl |=> (reg_rdata & 16'hff0c) == 16'h0000)
      else $error("control reserved bits read nonzero");
   status_rsvd_zero_a: assert property (rd_st |=> (reg_rdata & 16'hff9d) == 16'h0000)
      else $error("status reserved bits read nonzero");
   clk_out_en_a: assert property (ctrl_wr && reg_req.wdata[1:0] == `CKE_INT_OUT |=> serial_clock_pin_oe)
      else $error("clock pin not driven in internal out mode");
   clk_in_dir_a: assert property (ctrl_wr && reg_req.wdata[1:0] != `CKE_INT_OUT |=> !serial_clock_pin_oe)
      else $error("clock pin driven in input mode");
   tx_irq_mask_a: assert property (ctrl_wr && !reg_req.wdata[`CTRL_TIE] |=> !tx_irq)
      else $error("transmit request stays with enable off");
   rx_irq_mask_a: assert property (ctrl_wr && !reg_req.wdata[`CTRL_RIE] |=> !rx_irq)
      else $error("receive request stays with enable off");
   tx_start_gate_a: assert property (tx_data_ready |-> tx_active)
      else $error("transmit offered while disabled");
   rx_start_gate_a: assert property (rx_accept |-> rx_active)
      else $error("receive accepted while disabled");
   tx_clear_seq_a: assert property (tx_flag_seen ##0 tx_flag_zeroed |=> !tx_irq)
      else $error("transmit stop flag not cleared after read");
   rx_port_rd_a: assert property (rx_fifo_rd |-> reg_req.rd && reg_req.addr == `OFS_RX_PORT)
      else $error("receive storage popped without a port read");
endmodule : sync_serial_chk

bind sync_serial_ctrl_status sync_serial_chk u_sync_serial_chk (.sys_clk, .rst_n, .reg_req,
   .reg_rdata, .tx_load, .tx_data_ready, .rx_accept, .rx_fifo_rd, .tx_active, .rx_active,
   .serial_clock_pin_oe, .tx_irq, .rx_irq);

// [tb/fifo_side_model.sv]
// Purpose: Storage and shifter model on the far side of the control block
// Assumes: One byte in flight at a time
// Notes: Char time 8 or 40 cycles; idle read data inverts every cycle
`timescale 1ns/1ps
module fifo_side_model
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic rx_go,
   input wire logic tx_fifo_wr,
   input wire logic [7:0] tx_fifo_wdata,
   input wire logic tx_data_ready,
   input wire logic tx_fifo_clear,
   input wire logic rx_accept,
   input wire logic rx_fifo_rd,
   input wire logic rx_fifo_clear,
   output logic tx_load,
   output logic tx_char_done,
   output logic rx_byte_valid,
   output logic [7:0] rx_fifo_rdata
);
   logic [7:0] tx_q[$];
   logic [7:0] rx_q[$];
   logic [7:0] rx_seq_q;
   int bit_cnt_q;
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_q.delete(); rx_q.delete(); bit_cnt_q <= 0; rx_seq_q <= 8'h81;
         tx_load <= 1'b0; tx_char_done <= 1'b0; rx_byte_valid <= 1'b0;
         rx_fifo_rdata <= 8'h00;
      end
      else
      begin
         tx_load <= 1'b0;
         tx_char_done <= 1'b0;
         rx_byte_valid <= rx_go && rx_accept && !rx_byte_valid;
         rx_fifo_rdata <= ~rx_fifo_rdata;
         if (tx_fifo_wr) tx_q.push_back(tx_fifo_wdata);
         if (tx_fifo_clear) tx_q.delete();
         if (bit_cnt_q > 1) bit_cnt_q <= bit_cnt_q - 1;
         else if (bit_cnt_q == 1)
         begin
            bit_cnt_q <= 0;
            tx_char_done <= 1'b1;
         end
         else if (tx_data_ready && tx_q.size() > 0 && !tx_load)
         begin
            void'(tx_q.pop_front());
            tx_load <= 1'b1;
            bit_cnt_q <= slow ? 40 : 8;
         end
         if (rx_byte_valid && rx_accept)
         begin
            rx_q.push_back(rx_seq_q);
            rx_seq_q <= rx_seq_q + 8'h01;
         end
         if (rx_fifo_rd && rx_q.size() > 0) rx_fifo_rdata <= rx_q.pop_front();
         if (rx_fifo_clear) rx_q.delete();
      end
   end
endmodule : fifo_side_model

// [tb/sync_serial_ctrl_status_bench.sv]
// Purpose: Self-checking bench of the serial control block
// Assumes: Far side played by the storage model
// Notes: One task per scenario
`timescale 1ns/1ps
`include "sync_serial_defines.svh"
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module sync_serial_ctrl_status_bench;
   import sync_serial_pkg::*;
   logic sys_clk, rst_n, slow, rx_go, serial_clock_pin_i, tx_fifo_wr, tx_data_ready;
   logic tx_load, tx_char_done, rx_byte_valid, rx_accept, rx_fifo_rd, tx_fifo_clear;
   logic rx_fifo_clear, tx_active, rx_active, serial_clock_pin_o, serial_clock_pin_oe;
   logic tx_irq, rx_irq;
   logic [7:0] tx_fifo_wdata, rx_fifo_rdata;
   logic [15:0] reg_rdata;
   reg_req_s reg_req;
   sclk_s serial_clk;
   int bad_count, samples_checked;
   sync_serial_ctrl_status u_sync_serial_ctrl_status (.sys_clk, .rst_n, .reg_req, .reg_rdata,
      .tx_fifo_wr, .tx_fifo_wdata, .tx_load, .tx_char_done, .tx_data_ready, .rx_byte_valid,
      .rx_accept, .rx_fifo_rd, .rx_fifo_rdata, .tx_fifo_clear, .rx_fifo_clear, .tx_active,
      .rx_active, .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe,
      .serial_clk, .tx_irq, .rx_irq);
   fifo_side_model u_fifo_side_model (.sys_clk, .rst_n, .slow, .rx_go, .tx_fifo_wr,
      .tx_fifo_wdata, .tx_data_ready, .tx_fifo_clear, .rx_accept, .rx_fifo_rd,
      .rx_fifo_clear, .tx_load, .tx_char_done, .rx_byte_valid, .rx_fifo_rdata);
   // ****************************************
   // Bus and wait helpers
   // ****************************************
   task automatic bus(input logic [4:0] a, input logic [15:0] d, input logic w);
      @(posedge sys_clk);
      reg_req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge sys_clk);
      reg_req <= '0;
      #1;
   endtask : bus
   task automatic rd_then_clr();
      @(posedge sys_clk);
      reg_req <= '{addr: `OFS_STATUS, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      reg_req <= '{addr: `OFS_STATUS, wdata: 16'h0000, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      reg_req <= '0;
      #1;
   endtask : rd_then_clr
   task automatic wait_for(ref logic s, input int n);
      for (int i = 0; i < n && s !== 1'b1; i++) @(posedge sys_clk);
      #1;
   endtask : wait_for
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic reset_values();
      bus(`OFS_CTRL, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h0000)
      bus(`OFS_STATUS, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h0040)
      bus(`OFS_BIT_RATE, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h00ff)
   endtask : reset_values
   task automatic ctrl_fields();
      bus(`OFS_CTRL, 16'h00ff, 1'b1);
      bus(`OFS_CTRL, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h00f3)
      `CHECK(serial_clock_pin_oe, 1'b0)
      @(posedge sys_clk) serial_clock_pin_i <= 1'b0;
      #1;
      `CHECK(serial_clk, 3'b001)
      @(posedge sys_clk) serial_clock_pin_i <= 1'b1;
      #1;
      `CHECK(serial_clk, 3'b110)
      bus(`OFS_CTRL, 16'h0001, 1'b1); `CHECK(serial_clock_pin_oe, 1'b1)
      bus(`OFS_CTRL, 16'h0000, 1'b1); `CHECK(serial_clock_pin_oe, 1'b0)
      bus(`OFS_STATUS, 16'hffff, 1'b1);
      bus(`OFS_STATUS, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h0040)
      bus(`OFS_BIT_RATE, 16'h005a, 1'b1);
      bus(`OFS_BIT_RATE, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h005a)
      bus(5'h1e, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h0000)
   endtask : ctrl_fields
   task automatic baud_rates();
      int cyc;
      bus(`OFS_BIT_RATE, 16'h0001, 1'b1);
      bus(`OFS_CTRL, 16'h0021, 1'b1);
      for (int n = 0; n < 4; n++)
      begin
         bus(`OFS_CLK_SEL, 16'(n), 1'b1);
         repeat (3)
         begin
            cyc = 0;
            do
            begin
               @(posedge sys_clk);
               #1;
               cyc++;
            end while (serial_clk.rise !== 1'b1 && cyc < 2000);
         end
         `CHECK(cyc, 8 << (2 * n))
         `CHECK(serial_clock_pin_o, 1'b0)
      end
      bus(`OFS_CTRL, 16'h0000, 1'b1);
      bus(`OFS_CLK_SEL, 16'h0000, 1'b1);
   endtask : baud_rates
   task automatic tx_stop();
      bus(`OFS_TX_PORT, 16'h00a5, 1'b1);
      repeat (20) @(posedge sys_clk);
      `CHECK(tx_data_ready, 1'b0)
      bus(`OFS_STATUS, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h0000)
      bus(`OFS_FIFO_CTL, 16'h0004, 1'b1);
      bus(`OFS_FIFO_CTL, 16'h0000, 1'b1);
      bus(`OFS_LINE, 16'h0110, 1'b1);
      bus(`OFS_CTRL, 16'h00a0, 1'b1);
      slow = 1'b1;
      bus(`OFS_TX_PORT, 16'h003c, 1'b1);
      `CHECK({tx_fifo_wr, tx_fifo_wdata}, 9'h13c)
      bus(`OFS_TX_PORT, 16'h00c3, 1'b1);
      wait_for(tx_irq, 500); `CHECK(tx_irq, 1'b1)
      bus(`OFS_STATUS, 16'h0000, 1'b1); `CHECK(tx_irq, 1'b1)
      rd_then_clr(); `CHECK(tx_irq, 1'b0)
      repeat (100) @(posedge sys_clk);
      bus(`OFS_STATUS, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h0040)
      bus(`OFS_CTRL, 16'h0000, 1'b1);
   endtask : tx_stop
   task automatic rx_stop();
      bus(`OFS_FIFO_CTL, 16'h0002, 1'b1);
      bus(`OFS_FIFO_CTL, 16'h0000, 1'b1);
      bus(`OFS_LINE, 16'h0112, 1'b1);
      bus(`OFS_CTRL, 16'h0050, 1'b1);
      rx_go = 1'b1;
      wait_for(rx_irq, 200);
      rx_go = 1'b0;
      `CHECK(rx_irq, 1'b1)
      bus(`OFS_RX_CNT, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h0002)
      bus(`OFS_CTRL, 16'h0040, 1'b1);
      bus(`OFS_STATUS, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h0042)
      bus(`OFS_RX_PORT, 16'h0000, 1'b0); `CHECK(reg_rdata[7:0], 8'h81)
      bus(`OFS_CTRL, 16'h0000, 1'b1); `CHECK(rx_irq, 1'b0)
      rd_then_clr();
      bus(`OFS_STATUS, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h0040)
      bus(`OFS_FIFO_CTL, 16'h0002, 1'b1);
      bus(`OFS_FIFO_CTL, 16'h0000, 1'b1);
      bus(`OFS_RX_PORT, 16'h0000, 1'b0);
      bus(`OFS_RX_CNT, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h0000)
   endtask : rx_stop
   task automatic rx_full();
      bus(`OFS_LINE, 16'h0000, 1'b1);
      bus(`OFS_CTRL, 16'h0050, 1'b1);
      rx_go = 1'b1;
      wait_for(rx_irq, 2000);
      rx_go = 1'b0;
      `CHECK(rx_irq, 1'b1)
      bus(`OFS_RX_CNT, 16'h0000, 1'b0); `CHECK(reg_rdata, 16'h0180)
   endtask : rx_full
   // ****************************************
   // Run control
   // ****************************************
   task automatic give_verdict();
      if (bad_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      give_verdict();
   end
   initial
   begin
      reg_req = '0;
      rst_n = 1'b0;
      rx_go = 1'b0;
      slow = 1'b0;
      serial_clock_pin_i = 1'b1;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      reset_values();
      ctrl_fields();
      baud_rates();
      tx_stop();
      rx_stop();
      rx_full();
      give_verdict();
   end
endmodule : sync_serial_ctrl_status_bench
